// ### verilog/drs_pkg.sv
// drs_pkg: shared constants and types for the dma request-select and priority block
package drs_pkg;

   // ------------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------------
   localparam int NCH     = 4;
   localparam int NSRC    = 9;
   localparam int GRANT_W = 7;

   // ------------------------------------------------------------------
   // register map (byte offsets, one aligned word each)
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_CHCTL0   = 8'h00;
   localparam logic [7:0] OFS_CHSTRIDE = 8'h04;
   localparam logic [7:0] OFS_OPCTL    = 8'h10;
   localparam logic [7:0] OFS_STATUS   = 8'h14;

   // channel_control fields
   localparam int CC_SEL_LSB  = 0;
   localparam int CC_ENABLE   = 4;
   localparam int CC_BURST    = 5;
   localparam int CC_XFER_END = 6;

   // dma_operation_control fields
   localparam int OC_MASTER  = 0;
   localparam int OC_NMI     = 1;
   localparam int OC_AE      = 2;
   localparam int OC_PRI_LSB = 8;

   // status fields
   localparam int ST_PEND_LSB = 0;
   localparam int ST_CUR_LSB  = 4;
   localparam int ST_BUSY     = 6;
   localparam int ST_TOP_LSB  = 8;

   // ------------------------------------------------------------------
   // priority modes and fixed orders (two bits per rank, rank 0 lowest bits)
   // ------------------------------------------------------------------
   localparam logic [1:0] PRI_FIX0 = 2'h0;
   localparam logic [1:0] PRI_FIX1 = 2'h1;
   localparam logic [1:0] PRI_FIX2 = 2'h2;
   localparam logic [1:0] PRI_RR   = 2'h3;

   localparam logic [7:0] ORDER_FIX0 = 8'he4;
   localparam logic [7:0] ORDER_FIX1 = 8'h78;
   localparam logic [7:0] ORDER_FIX2 = 8'hd2;

   // ------------------------------------------------------------------
   // request select codes and peripheral trigger indices
   // ------------------------------------------------------------------
   localparam logic [3:0] SEL_TIMER_CM6    = 4'h6;
   localparam logic [3:0] SEL_TIMER_ICB    = 4'h7;
   localparam logic [3:0] SEL_SERIAL_FIRST = 4'h8;
   localparam logic [3:0] SEL_SERIAL_LAST  = 4'hd;
   localparam logic [3:0] SEL_CONV_0       = 4'he;
   localparam logic [3:0] SEL_CONV_1       = 4'hf;

   localparam logic [3:0] SRC_TIMER_CM6    = 4'h0;
   localparam logic [3:0] SRC_TIMER_ICB    = 4'h1;
   localparam logic [3:0] SRC_SERIAL_FIRST = 4'h2;
   localparam logic [3:0] SRC_CONV         = 4'h8;

   localparam int HTRANS_ACTIVE_BIT = 1;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_WAIT = 2'b10
   } drs_state_t;

   // address that the granted transfer is bound to
   typedef enum logic [1:0] {
      FIX_NONE     = 2'h0,
      FIX_DST_TX   = 2'h1,
      FIX_SRC_RX   = 2'h2,
      FIX_SRC_CONV = 2'h3
   } drs_fix_t;

endpackage : drs_pkg

// ### verilog/drs_periph_if.sv
// drs_periph_if: trigger link between peripheral modules and the dma request block
`timescale 1ns/1ps
`default_nettype none
interface drs_periph_if;
   logic [drs_pkg::NSRC-1:0] trig_req;
   logic [drs_pkg::NSRC-1:0] trig_clear;
   logic [drs_pkg::NSRC-1:0] dma_owns;

   modport dev (input trig_req, output trig_clear, output dma_owns);
   modport per (output trig_req, input trig_clear, input dma_owns);
endinterface : drs_periph_if
`default_nettype wire

// ### verilog/drs_buf2.sv
// drs_buf2: two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module drs_buf2 #(
   parameter int W = 8
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   logic [W-1:0] mem_ff [2];
   logic         wr_ptr_ff;
   logic         rd_ptr_ff;
   logic [1:0]   cnt_ff;
   logic         push;
   logic         pop;

   assign in_ready  = (cnt_ff != 2'h2);
   assign out_valid = (cnt_ff != 2'h0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_ff[rd_ptr_ff];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         cnt_ff    <= 2'h0;
      end else begin
         if (push) wr_ptr_ff <= ~wr_ptr_ff;
         if (pop) rd_ptr_ff <= ~rd_ptr_ff;
         cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
      end
   end

   // storage needs no reset: nothing reads an entry before it is written
   always_ff @(posedge hclk) begin
      if (push) mem_ff[wr_ptr_ff] <= in_data;
   end
endmodule : drs_buf2
`default_nettype wire

// ### verilog/drs_dma_end.sv
// drs_dma_end: request selection, pending hold and channel arbitration of the dma side
//
// Behaviour
// - transfer on trigger only while fully enabled
// - codes 0110/0111 route timer compare and capture
// - codes 1000-1101 route serial tx/rx triggers
// - software points tx-triggered destination at tx holding
// - software points rx-triggered source at rx holding
// - codes 1110/1111 conversion end, fixed result source
// - free addresses exclude dma, bus, break controllers
// - peripheral triggers only with its interrupt enabled
// - suppress cpu interrupt of a trigger in use
// - clear trigger: cycle-steal first, burst last unit
// - grant exactly one channel per priority mode
// - three fixed orders never change
// - mode 00/01/10 fixed orders, 11 round robin
// - finished channel drops to lowest in round robin
// - round robin starts 0>1>2>3 after reset
// - demotion rotates, cyclic order kept
// - no preemption; re-arbitrate after each transfer
//
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module drs_dma_end (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic                    hreadyout,
   output logic [31:0]             hrdata,
   output logic                    hresp,
   drs_periph_if.dev               periph,
   input  wire logic               nmi_event,
   input  wire logic               addr_error_event,
   output logic                    grant_valid,
   input  wire logic               grant_ready,
   output logic [1:0]              grant_channel,
   output drs_pkg::drs_fix_t       grant_fix,
   output logic [1:0]              grant_fix_index,
   output logic                    grant_burst,
   input  wire logic               unit_done,
   input  wire logic               unit_last
);
   localparam int N = drs_pkg::NCH;

   // ------------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------------
   // returns {ok, source[3:0], fix[1:0], fix_index[1:0]}
   function automatic logic [8:0] decode_sel(input logic [3:0] code);
      logic [3:0] off;
      logic [8:0] r;
      off = code - drs_pkg::SEL_SERIAL_FIRST;
      r   = 9'h000;
      if (code == drs_pkg::SEL_TIMER_CM6)
         r = {1'b1, drs_pkg::SRC_TIMER_CM6, drs_pkg::FIX_NONE, 2'h0};
      else if (code == drs_pkg::SEL_TIMER_ICB)
         r = {1'b1, drs_pkg::SRC_TIMER_ICB, drs_pkg::FIX_NONE, 2'h0};
      else if (code >= drs_pkg::SEL_SERIAL_FIRST && code <= drs_pkg::SEL_SERIAL_LAST)
         r = {1'b1, drs_pkg::SRC_SERIAL_FIRST + off,
              (off[0] ? drs_pkg::FIX_SRC_RX : drs_pkg::FIX_DST_TX), off[2:1]};
      else if (code == drs_pkg::SEL_CONV_0)
         r = {1'b1, drs_pkg::SRC_CONV, drs_pkg::FIX_SRC_CONV, 2'h0};
      else if (code == drs_pkg::SEL_CONV_1)
         r = {1'b1, drs_pkg::SRC_CONV, drs_pkg::FIX_SRC_CONV, 2'h1};
      return r;
   endfunction : decode_sel

   // returns {found, channel[1:0]}; scans lowest rank first so the highest wins
   function automatic logic [2:0] pick(input logic [3:0] req, input logic [1:0] pri,
                                       input logic [1:0] top);
      logic [7:0] tbl;
      logic [1:0] c;
      logic [2:0] r;
      r = 3'h0;
      c = 2'h0;
      case (pri)
         drs_pkg::PRI_FIX0: tbl = drs_pkg::ORDER_FIX0;
         drs_pkg::PRI_FIX1: tbl = drs_pkg::ORDER_FIX1;
         drs_pkg::PRI_FIX2: tbl = drs_pkg::ORDER_FIX2;
         default:           tbl = 8'h00;
      endcase
      for (int p = N - 1; p >= 0; p--) begin
         if (pri == drs_pkg::PRI_RR) c = top + 2'(p);
         else c = tbl[2*p +: 2];
         if (req[c]) r = {1'b1, c};
      end
      return r;
   endfunction : pick

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic [3:0]          sel_ff [N];
   logic [N-1:0]        en_ff;
   logic [N-1:0]        burst_ff;
   logic [N-1:0]        te_ff;
   logic [N-1:0]        pending_ff;
   logic                master_ff;
   logic                nmi_ff;
   logic                ae_ff;
   logic                nmi_seen_ff;
   logic                ae_seen_ff;
   logic [1:0]          pri_ff;
   logic [1:0]          top_ff;
   logic [1:0]          cur_ff;
   drs_pkg::drs_state_t state_ff;
   logic                wr_ff;
   logic [7:0]          waddr_ff;
   logic                rd_pend_ff;
   logic [7:0]          raddr_ff;
   logic [31:0]         hrdata_ff;

   // ------------------------------------------------------------------
   // ahb-lite slave: writes zero-wait, reads one wait state so that a
   // read right behind a write sees the written value
   // ------------------------------------------------------------------
   logic        addr_ph;
   logic        wr_op;
   logic        op_hit;
   logic [31:0] rd_mux;
   logic [31:0] chctl_rd [N];
   logic [N-1:0] ch_hit;

   assign addr_ph   = hsel & htrans[drs_pkg::HTRANS_ACTIVE_BIT] & hready;
   assign hreadyout = ~rd_pend_ff;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_ff;
   assign wr_op     = wr_ff & (waddr_ff == drs_pkg::OFS_OPCTL);
   assign op_hit    = (raddr_ff == drs_pkg::OFS_OPCTL);

   // ------------------------------------------------------------------
   // per-channel decode and eligibility
   // ------------------------------------------------------------------
   logic [8:0]   dec      [N];
   logic [N-1:0] eligible;
   logic [N-1:0] trig_ch;
   logic [N-1:0] clr_ch;
   logic [N-1:0] wr_ch;
   logic [N-1:0] req;
   logic [2:0]   win;
   logic         svc;
   logic         clr_now;
   logic         buf_in_ready;
   logic         push;
   logic [drs_pkg::GRANT_W-1:0] buf_out;

   assign svc     = unit_done & (state_ff == drs_pkg::ST_WAIT);
   assign clr_now = svc & (~burst_ff[cur_ff] | unit_last);

   for (genvar c = 0; c < N; c++) begin : g_ch
      assign dec[c]      = decode_sel(sel_ff[c]);
      assign eligible[c] = en_ff[c] & master_ff & ~te_ff[c] & ~nmi_ff & ~ae_ff;
      assign trig_ch[c]  = dec[c][8] & periph.trig_req[dec[c][7:4]];
      assign clr_ch[c]   = clr_now & (cur_ff == 2'(c));
      assign wr_ch[c]    = wr_ff & (waddr_ff == drs_pkg::OFS_CHCTL0 + 8'(c) * drs_pkg::OFS_CHSTRIDE);
      assign ch_hit[c]   = (raddr_ff == drs_pkg::OFS_CHCTL0 + 8'(c) * drs_pkg::OFS_CHSTRIDE);
      assign req[c]      = pending_ff[c] & eligible[c];
      assign chctl_rd[c] = {25'h0, te_ff[c], burst_ff[c], en_ff[c], sel_ff[c]};

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            sel_ff[c]     <= 4'h0;
            en_ff[c]      <= 1'b0;
            burst_ff[c]   <= 1'b0;
            te_ff[c]      <= 1'b0;
            pending_ff[c] <= 1'b0;
         end else begin
            if (wr_ch[c]) begin
               sel_ff[c]   <= hwdata[drs_pkg::CC_SEL_LSB +: 4];
               en_ff[c]    <= hwdata[drs_pkg::CC_ENABLE];
               burst_ff[c] <= hwdata[drs_pkg::CC_BURST];
               te_ff[c]    <= hwdata[drs_pkg::CC_XFER_END];
            end
            if (svc && unit_last && cur_ff == 2'(c)) te_ff[c] <= 1'b1;
            // a trigger still high while its clear goes out must not re-arm
            pending_ff[c] <= (pending_ff[c] & ~clr_ch[c]) | (trig_ch[c] & ~clr_ch[c]);
         end
      end
   end

   // ------------------------------------------------------------------
   // trigger clear and cpu interrupt suppression
   // ------------------------------------------------------------------
   always_comb begin
      periph.trig_clear = '0;
      periph.dma_owns   = '0;
      if (clr_now) periph.trig_clear[dec[cur_ff][7:4]] = 1'b1;
      for (int c = 0; c < N; c++) begin
         if (en_ff[c] && dec[c][8]) periph.dma_owns[dec[c][7:4]] = 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // arbiter: one grant outstanding; new requests wait until it is done
   // ------------------------------------------------------------------
   assign win  = pick(req, pri_ff, top_ff);
   assign push = (state_ff == drs_pkg::ST_IDLE) & win[2] & buf_in_ready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= drs_pkg::ST_IDLE;
         cur_ff   <= 2'h0;
         top_ff   <= 2'h0;
      end else begin
         case (state_ff)
            drs_pkg::ST_IDLE: begin
               if (push) begin
                  cur_ff   <= win[1:0];
                  state_ff <= drs_pkg::ST_WAIT;
               end
            end
            drs_pkg::ST_WAIT: begin
               if (unit_done) begin
                  if (pri_ff == drs_pkg::PRI_RR) top_ff <= cur_ff + 2'h1;
                  state_ff <= drs_pkg::ST_IDLE;
               end
            end
            default: state_ff <= drs_pkg::ST_IDLE;
         endcase
      end
   end

   drs_buf2 #(
      .W (drs_pkg::GRANT_W)
   ) u_grant_buf (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .in_valid  (push),
      .in_ready  (buf_in_ready),
      .in_data   ({burst_ff[win[1:0]], dec[win[1:0]][1:0], dec[win[1:0]][3:2], win[1:0]}),
      .out_valid (grant_valid),
      .out_ready (grant_ready),
      .out_data  (buf_out)
   );

   assign grant_channel   = buf_out[1:0];
   assign grant_fix       = drs_pkg::drs_fix_t'(buf_out[3:2]);
   assign grant_fix_index = buf_out[5:4];
   assign grant_burst     = buf_out[6];

   // ------------------------------------------------------------------
   // operation control, flags and read path
   // ------------------------------------------------------------------
   always_comb begin
      rd_mux = 32'h0;
      for (int c = 0; c < N; c++) begin
         if (ch_hit[c]) rd_mux = chctl_rd[c];
      end
      if (op_hit) rd_mux = {22'h0, pri_ff, 5'h0, ae_ff, nmi_ff, master_ff};
      if (raddr_ff == drs_pkg::OFS_STATUS)
         rd_mux = {22'h0, top_ff, 1'b0, (state_ff == drs_pkg::ST_WAIT), cur_ff, pending_ff};
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ff       <= 1'b0;
         waddr_ff    <= 8'h00;
         rd_pend_ff  <= 1'b0;
         raddr_ff    <= 8'h00;
         hrdata_ff   <= 32'h0;
         master_ff   <= 1'b0;
         pri_ff      <= drs_pkg::PRI_FIX0;
         nmi_ff      <= 1'b0;
         ae_ff       <= 1'b0;
         nmi_seen_ff <= 1'b0;
         ae_seen_ff  <= 1'b0;
      end else begin
         wr_ff      <= addr_ph & hwrite;
         rd_pend_ff <= addr_ph & ~hwrite;
         if (addr_ph) begin
            waddr_ff <= haddr[7:0];
            raddr_ff <= haddr[7:0];
         end
         if (rd_pend_ff) begin
            hrdata_ff <= rd_mux;
            if (op_hit && nmi_ff) nmi_seen_ff <= 1'b1;
            if (op_hit && ae_ff) ae_seen_ff <= 1'b1;
         end
         if (wr_op) begin
            master_ff <= hwdata[drs_pkg::OC_MASTER];
            pri_ff    <= hwdata[drs_pkg::OC_PRI_LSB +: 2];
         end
         // flags clear only by a zero write after a one was read; events win
         if (nmi_event) nmi_ff <= 1'b1;
         else if (wr_op && nmi_seen_ff && !hwdata[drs_pkg::OC_NMI]) nmi_ff <= 1'b0;
         if (addr_error_event) ae_ff <= 1'b1;
         else if (wr_op && ae_seen_ff && !hwdata[drs_pkg::OC_AE]) ae_ff <= 1'b0;
         if (wr_op) begin
            nmi_seen_ff <= 1'b0;
            ae_seen_ff  <= 1'b0;
         end
      end
   end
endmodule : drs_dma_end
`default_nettype wire

// ### verilog/drs_periph_end.sv
// drs_periph_end: peripheral side of the trigger link, holding each request flag
`timescale 1ns/1ps
`default_nettype none
module drs_periph_end (
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   drs_periph_if.per                     periph,
   input  wire logic [drs_pkg::NSRC-1:0] event_in,
   input  wire logic [drs_pkg::NSRC-1:0] irq_enable,
   output logic [drs_pkg::NSRC-1:0]      cpu_irq
);
   logic [drs_pkg::NSRC-1:0] flag_ff;

   // ------------------------------------------------------------------
   // request flags: a new event beats a clear in the same cycle
   // ------------------------------------------------------------------
   for (genvar s = 0; s < drs_pkg::NSRC; s++) begin : g_src
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) flag_ff[s] <= 1'b0;
         else if (event_in[s] && irq_enable[s]) flag_ff[s] <= 1'b1;
         else if (periph.trig_clear[s]) flag_ff[s] <= 1'b0;
      end
   end

   // data registers stay reachable by the dma as free addresses
   assign periph.trig_req = flag_ff;
   // the cpu sees only requests that the dma does not claim
   assign cpu_irq = flag_ff & ~periph.dma_owns;
endmodule : drs_periph_end
`default_nettype wire

// ### test/drs_props.sv
// drs_props: concurrent checks on the trigger link and the grant stream
`timescale 1ns/1ps
`default_nettype none
module drs_props (
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   input  wire logic [drs_pkg::NSRC-1:0] trig_req,
   input  wire logic [drs_pkg::NSRC-1:0] trig_clear,
   input  wire logic [drs_pkg::NSRC-1:0] dma_owns,
   input  wire logic [drs_pkg::NSRC-1:0] event_in,
   input  wire logic [drs_pkg::NSRC-1:0] irq_enable,
   input  wire logic [drs_pkg::NSRC-1:0] cpu_irq,
   input  wire logic                     grant_valid,
   input  wire logic                     grant_ready,
   input  wire logic [1:0]               grant_channel,
   input  wire logic                     unit_done
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // ------------------------------------------------------------------
   // trigger link
   // ------------------------------------------------------------------
   wire logic [drs_pkg::NSRC-1:0] armed = event_in & irq_enable;

   AST_IRQ_MASKED: assert property (cpu_irq == (trig_req & ~dma_owns))
      else $error("cpu interrupt not masked by dma ownership");
   AST_REQ_SETS: assert property (|armed |=> ((trig_req & $past(armed)) == $past(armed)))
      else $error("enabled event did not raise its request");
   AST_REQ_GATED: assert property (((trig_req & ~$past(trig_req)) & ~$past(armed)) == '0)
      else $error("request rose without an enabled event");
   AST_CLEAR_HELD: assert property (|trig_clear |-> ((trig_clear & ~trig_req) == '0))
      else $error("clear pulse for a request that is not raised");
   AST_CLEAR_DROPS: assert property
      (|trig_clear |=> ((trig_req & $past(trig_clear) & ~$past(armed)) == '0))
      else $error("request still raised after its clear");

   // ------------------------------------------------------------------
   // grant stream
   // ------------------------------------------------------------------
   AST_GRANT_HOLDS: assert property
      (grant_valid && !grant_ready |=> grant_valid && $stable(grant_channel))
      else $error("grant changed before it was taken");
   AST_NO_PREEMPT: assert property
      (grant_valid && grant_ready && !unit_done |=> !grant_valid)
      else $error("new grant before the running unit ended");
   AST_GRANT_OWNED: assert property ($rose(grant_valid) |-> |dma_owns)
      else $error("grant without an enabled peripheral channel");
endmodule : drs_props
`default_nettype wire

// ### test/testbench.sv
// testbench: both ends of the trigger link with register-driven arbitration checks
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, nmi_event = 1'b0;
   logic grant_ready = 1'b0, unit_done = 1'b0, unit_last = 1'b0, ae_event = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic [8:0]  event_in = 9'h0, irq_enable = 9'h1ff;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, grant_valid, grant_burst;
   logic [1:0]  grant_channel, grant_fix_index;
   logic [8:0]  cpu_irq;
   drs_pkg::drs_fix_t grant_fix;
   int mismatches = 0, n_tests = 0;
   logic [1:0] ord [3][4] = '{'{2'h0, 2'h1, 2'h2, 2'h3}, '{2'h0, 2'h2, 2'h3, 2'h1},
                             '{2'h2, 2'h0, 2'h1, 2'h3}};

   always #25 hclk = ~hclk;

   drs_periph_if link ();
   drs_dma_end drs_dma_end_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .periph(link),
      .nmi_event(nmi_event), .addr_error_event(ae_event), .grant_valid(grant_valid),
      .grant_ready(grant_ready), .grant_channel(grant_channel), .grant_fix(grant_fix),
      .grant_fix_index(grant_fix_index), .grant_burst(grant_burst), .unit_done(unit_done),
      .unit_last(unit_last));
   drs_periph_end drs_periph_end_inst (.hclk(hclk), .hresetn(hresetn), .periph(link),
      .event_in(event_in), .irq_enable(irq_enable), .cpu_irq(cpu_irq));
   drs_props drs_props_inst (.hclk(hclk), .hresetn(hresetn), .trig_req(link.trig_req),
      .trig_clear(link.trig_clear), .dma_owns(link.dma_owns), .event_in(event_in),
      .irq_enable(irq_enable), .cpu_irq(cpu_irq), .grant_valid(grant_valid),
      .grant_ready(grant_ready), .grant_channel(grant_channel), .unit_done(unit_done));

   // ------------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task conclude;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude

   // ready is judged at the negedge so the decision matches the next rising edge
   task rdy;
      @(negedge hclk);
      while (hreadyout !== 1'b1) @(negedge hclk);
      @(posedge hclk);
   endtask : rdy

   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      rdy();
      rd = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask : ahb

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask : wr

   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      ahb(1'b0, a, 32'h0, x);
      chk(x, exp);
   endtask : rd_chk

   task ev(input logic [8:0] m);
      event_in <= m;
      @(posedge hclk);
      event_in <= 9'h0;
   endtask : ev

   // wait for a grant, check it, take it, end one unit and check the clear pulse
   task serve(input logic [1:0] ch, input logic [1:0] fx, input logic [1:0] ix,
              input logic last, input logic clr);
      logic c;
      @(negedge hclk);
      while (grant_valid !== 1'b1) @(negedge hclk);
      chk({30'h0, grant_channel}, {30'h0, ch});
      chk({30'h0, grant_fix}, {30'h0, fx});
      if (fx !== 2'h0) chk({30'h0, grant_fix_index}, {30'h0, ix});
      chk({31'h0, grant_burst}, {31'h0, last | ~clr});
      @(posedge hclk);
      grant_ready <= 1'b1;
      @(posedge hclk);
      grant_ready <= 1'b0;
      unit_done <= 1'b1;
      unit_last <= last;
      @(negedge hclk);
      c = |link.trig_clear;
      chk({31'h0, c}, {31'h0, clr});
      @(posedge hclk);
      unit_done <= 1'b0;
      unit_last <= 1'b0;
   endtask : serve

   // ------------------------------------------------------------------
   // tests
   // ------------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      conclude();
   end

   initial begin
      int c, src, m, k;
      logic [1:0] fx, ix;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(8'h10, 32'h0);
      rd_chk(8'h14, 32'h0);
      rd_chk(8'h20, 32'h0);
      wr(8'h10, 32'h1);
      for (c = 6; c < 16; c++) begin
         src = (c < 14) ? c - 6 : 8;
         fx = (c < 8) ? 2'h0 : (c >= 14) ? 2'h3 : (c[0] ? 2'h2 : 2'h1);
         ix = (c < 14) ? 2'((c - 8) >>> 1) : 2'(c - 14);
         wr(8'h00, 32'h10 | 32'(c));
         ev(9'(1 << src));
         @(negedge hclk);
         chk({23'h0, cpu_irq}, 32'h0);
         serve(2'h0, fx, ix, 1'b0, 1'b1);
         @(negedge hclk);
         chk({23'h0, link.trig_req}, 32'h0);
         @(posedge hclk);
      end
      irq_enable <= 9'h1fb;
      ev(9'h006);
      repeat (3) @(posedge hclk);
      chk({23'h0, link.trig_req}, 32'h2);
      chk({23'h0, cpu_irq}, 32'h2);
      irq_enable <= 9'h1ff;
      wr(8'h00, 32'h18);
      wr(8'h10, 32'h0);
      ev(9'h004);
      repeat (4) @(posedge hclk);
      chk({31'h0, grant_valid}, 32'h0);
      rd_chk(8'h14, 32'h1);
      nmi_event <= 1'b1;
      ae_event <= 1'b1;
      @(posedge hclk);
      nmi_event <= 1'b0;
      ae_event <= 1'b0;
      wr(8'h10, 32'h1);
      rd_chk(8'h10, 32'h7);
      repeat (3) @(posedge hclk);
      chk({31'h0, grant_valid}, 32'h0);
      wr(8'h10, 32'h1);
      rd_chk(8'h10, 32'h1);
      serve(2'h0, 2'h1, 2'h0, 1'b0, 1'b1);
      wr(8'h04, 32'h1a);
      wr(8'h08, 32'h1c);
      wr(8'h0c, 32'h16);
      for (m = 0; m < 3; m++) begin
         wr(8'h10, 32'h1 | 32'(m << 8));
         ev(9'h055);
         for (k = 0; k < 4; k++) begin
            serve(ord[m][k], (ord[m][k] == 2'h3) ? 2'h0 : 2'h1, ord[m][k], 1'b0, 1'b1);
         end
      end
      rd_chk(8'h14, 32'h30);
      wr(8'h10, 32'h301);
      ev(9'h005);
      @(posedge hclk);
      ev(9'h010);
      serve(2'h0, 2'h1, 2'h0, 1'b0, 1'b1);
      serve(2'h1, 2'h1, 2'h1, 1'b0, 1'b1);
      serve(2'h3, 2'h0, 2'h0, 1'b0, 1'b1);
      ev(9'h010);
      serve(2'h1, 2'h1, 2'h1, 1'b0, 1'b1);
      ev(9'h055);
      for (k = 0; k < 4; k++) begin
         serve(2'(k + 2), (k == 1) ? 2'h0 : 2'h1, 2'(k + 2), 1'b0, 1'b1);
      end
      rd_chk(8'h14, 32'h210);
      wr(8'h00, 32'h38);
      ev(9'h004);
      serve(2'h0, 2'h1, 2'h0, 1'b0, 1'b0);
      serve(2'h0, 2'h1, 2'h0, 1'b0, 1'b0);
      serve(2'h0, 2'h1, 2'h0, 1'b1, 1'b1);
      rd_chk(8'h00, 32'h78);
      ev(9'h004);
      repeat (4) @(posedge hclk);
      chk({31'h0, grant_valid}, 32'h0);
      conclude();
   end
endmodule : testbench
`default_nettype wire
